//--- hw/dsp_load_pkg.sv
// Purpose: Shared constants and types of the register-load datapath
// Assumes: 32-bit Avalon-MM register slave, byte offsets, one word per register, two words per accumulator
// Notes:   Event bits share one layout in status and mask registers
package dsp_load_pkg;
	localparam int ADDR_W = 7;
	localparam int MEM_AW = 16;
	localparam int ACC_W  = 40;
	localparam int N_ACC  = 4;
	localparam int N_TA   = 8;
	localparam int N_EV   = 4;

	localparam logic [6:0] OFS_MODE   = 7'h00;
	localparam logic [6:0] OFS_CMD    = 7'h04;
	localparam logic [6:0] OFS_IMM    = 7'h08;
	localparam logic [6:0] OFS_PTR    = 7'h0C;
	localparam logic [6:0] OFS_STATE  = 7'h10;
	localparam logic [6:0] OFS_EVENT  = 7'h14;
	localparam logic [6:0] OFS_MASK   = 7'h18;
	localparam logic [6:0] OFS_ACC    = 7'h20;
	localparam logic [6:0] OFS_TA     = 7'h40;

	localparam logic [3:0] MODE_RST   = 4'h0;
	localparam logic [15:0] MAP_SPACE_END = 16'h0060;
	localparam logic [4:0] SHIFT_16   = 5'h10;

	localparam int EV_DONE    = 0;
	localparam int EV_OVF     = 1;
	localparam int EV_FAULT   = 2;
	localparam int EV_ILLEGAL = 3;

	localparam logic [39:0] SAT32_POS = 40'h00_7FFF_FFFF;
	localparam logic [39:0] SAT32_NEG = 40'hFF_8000_0000;
	localparam logic [39:0] SAT40_POS = 40'h7F_FFFF_FFFF;
	localparam logic [39:0] SAT40_NEG = 40'h80_0000_0000;

	typedef enum logic [2:0] {
		OP_PAIR_LO = 3'b000,
		OP_IMM_S16 = 3'b001,
		OP_IMM_SHV = 3'b010,
		OP_WORD    = 3'b011,
		OP_BYTE_HI = 3'b100,
		OP_BYTE_LO = 3'b101
	} op_e;

	typedef struct packed {
		logic       uns;
		logic [3:0] shift_amount_field;
		logic [3:0] dst;
		logic [2:0] op;
	} cmd_s;

	typedef struct packed {
		logic legacy_compat_mode;
		logic data_saturate_mode;
		logic wide_acc_mode;
		logic sign_ext_mode;
	} mode_s;
endpackage : dsp_load_pkg

//--- hw/imm_shifter.sv
// Purpose: Data-unit shifter for immediate accumulator loads
// Assumes: Left shifts of 0 to 16 positions only
// Notes:   Overflow checked at bit 31 or bit 39 depending on width mode
`timescale 1ns/10ps
module imm_shifter
	import dsp_load_pkg::*;
(
	input  wire logic [15:0] operand,   // Constant to load
	input  wire logic        sign_en,   // Sign-extend instead of zero
	input  wire logic [4:0]  shamt,     // Left shift count
	input  wire logic        wide,      // 40-bit result mode
	input  wire logic        det_en,    // Overflow detection on
	input  wire logic        sat_en,    // Saturate on overflow
	output logic      [39:0] result,    // Shifted value
	output logic             ovf        // Overflow seen
);
	logic [55:0] ext;
	logic [55:0] shifted;
	logic        ovf_raw;

	assign ext     = sign_en ? {{40{operand[15]}}, operand} : {40'h0, operand};
	assign shifted = ext << shamt;
	assign ovf_raw = wide ? (shifted[55:39] != {17{shifted[55]}})
	                      : (shifted[55:31] != {25{shifted[55]}});
	assign ovf     = det_en & ovf_raw;
	assign result  = (ovf & sat_en) ? (wide ? (shifted[55] ? SAT40_NEG : SAT40_POS)
	                                        : (shifted[55] ? SAT32_NEG : SAT32_POS))
	                                : shifted[39:0];
endmodule : imm_shifter

//--- hw/event_status.sv
// Purpose: Sticky event flags, mask and level interrupt
// Assumes: Clear pulse comes from an accepted read of the status register
// Notes:   A set in the clearing cycle wins over the clear
`timescale 1ns/10ps
module event_status #(
	parameter int N = 4
) (
	input  wire logic         core_clk,  // Core clock
	input  wire logic         reset,     // Sync reset, active high
	input  wire logic [N-1:0] ev_set,    // Event pulses
	input  wire logic         ev_clr,    // Read-clear pulse
	input  wire logic         mask_we,   // Mask write strobe
	input  wire logic [N-1:0] mask_wd,   // Mask write data
	output logic      [N-1:0] status,    // Sticky flags
	output logic      [N-1:0] mask,      // Enable mask
	output logic              irq        // Level interrupt
);
	logic [N-1:0] next_status;

	for (genvar i = 0; i < N; i++) begin : g_bit
		assign next_status[i] = ev_set[i] | (status[i] & ~ev_clr);
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			status <= '0;
			mask   <= '0;
			irq    <= 1'b0;
		end else begin
			status <= next_status;
			if (mask_we)
				mask <= mask_wd;
			irq    <= |(next_status & (mask_we ? mask_wd : mask));
		end
	end
endmodule : event_status

//--- hw/dsp_load_unit.sv
// Purpose: Register-load datapath: pair, immediate, word and byte loads
// Assumes: Data memory answers one cycle after a read strobe
// Notes:   Software issues loads through the command register
// How it works
// - Pair load puts upper word in acc low half, lower word in next acc.
// - Pair load targets only accumulators zero-one or two-three.
// - Second long word from pointer plus one when even, minus one when odd.
// - Immediate load places constant shifted left sixteen into accumulator.
// - Immediate constants extend to 40 bits, signed per sign-extension mode.
// - Shift-sixteen load uses all four modes and updates the overflow flag.
// - Variable immediate load shifts by the 4-bit field in the shifter.
// - Legacy mode skips saturation after shifting, and overflow detection and reporting for variable-shift loads only.
// - Word load to accumulator extends to 40 bits per sign-extension mode.
// - Word load to auxiliary or temporary register is always sign-extended.
// - Memory loads to accumulators bypass the arithmetic unit and shifter.
// - High-byte load takes the upper byte of the addressed word.
// - Low-byte load takes the lower byte of the addressed word.
// - Unsigned byte load zero-extends to 40 or 16 bits.
// - Signed byte load to auxiliary register is sign-extended regardless of mode.
// - Byte load from mapped register space is refused and raises bus fault.
// - Checked accumulator loads detect overflow at bit 31, or bit 39 in wide mode, and set flag.
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/10ps
module dsp_load_unit
	import dsp_load_pkg::*;
#(
	parameter logic [15:0] MAP_LIMIT = MAP_SPACE_END
) (
	input  wire logic              core_clk,          // Core clock, 125 MHz
	input  wire logic              reset,             // Sync reset, active high
	input  wire logic [ADDR_W-1:0] avs_address,       // Register byte address
	input  wire logic              avs_read,          // Read request
	input  wire logic              avs_write,         // Write request
	input  wire logic [31:0]       avs_writedata,     // Write data
	output logic      [31:0]       avs_readdata,      // Read data
	output logic                   avs_waitrequest,   // Stall the master
	output logic      [MEM_AW-1:0] mem_addr,          // Data memory address
	output logic                   mem_rd,            // Data memory read strobe
	input  wire logic [15:0]       mem_rdata,         // Data memory word
	output logic                   bus_fault_irq,     // Bus-error request pulse
	output logic      [N_ACC-1:0]  acc_overflow_flag, // Per-accumulator overflow
	output logic                   irq                // Level interrupt
);
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_LAT   = 3'b001,
		ST_DATA1 = 3'b010,
		ST_DATA2 = 3'b011,
		ST_EXEC  = 3'b100
	} state_e;

	state_e      state;
	mode_s       mode;
	cmd_s        cmd;
	logic [15:0] imm16_const;
	logic [15:0] ptr;
	logic [15:0] word_hi;
	logic [15:0] word_lo;
	logic [ACC_W-1:0] acc_reg [N_ACC];
	logic [15:0] ta_reg [N_TA];

	// Bus decode
	logic        req;
	logic        accept;
	logic        acc_wr;
	logic        acc_rd;
	logic        wr_mode;
	logic        wr_cmd;
	logic        wr_imm;
	logic        wr_ptr;
	logic        wr_mask;
	logic        rd_event;
	logic        busy;
	logic [31:0] rd_value;
	logic [1:0]  rd_acc_idx;
	logic [2:0]  rd_ta_idx;
	logic [39:0] rd_acc;

	assign busy     = (state != ST_IDLE);
	assign req      = avs_read | avs_write;
	assign accept   = req & ~avs_waitrequest;
	assign acc_wr   = accept & avs_write;
	assign acc_rd   = accept & avs_read;
	assign wr_mode  = acc_wr & (avs_address == OFS_MODE);
	assign wr_cmd   = acc_wr & (avs_address == OFS_CMD);
	assign wr_imm   = acc_wr & (avs_address == OFS_IMM);
	assign wr_ptr   = acc_wr & (avs_address == OFS_PTR);
	assign wr_mask  = acc_wr & (avs_address == OFS_MASK);
	assign rd_event = acc_rd & (avs_address == OFS_EVENT);

	// New command decode
	cmd_s        new_cmd;
	logic        new_is_byte;
	logic        new_needs_mem;
	logic        new_legal;
	logic        new_fault;

	assign new_cmd       = cmd_s'(avs_writedata[11:0]);
	assign new_is_byte   = (new_cmd.op == OP_BYTE_HI) | (new_cmd.op == OP_BYTE_LO);
	assign new_needs_mem = (new_cmd.op == OP_PAIR_LO) | (new_cmd.op == OP_WORD) | new_is_byte;
	assign new_legal = ((new_cmd.op == OP_PAIR_LO) & ~new_cmd.dst[3] & ~new_cmd.dst[0])
	                 | (((new_cmd.op == OP_IMM_S16) | (new_cmd.op == OP_IMM_SHV)) & ~new_cmd.dst[3])
	                 | (new_cmd.op == OP_WORD) | new_is_byte;
	assign new_fault = new_legal & new_is_byte & (ptr < MAP_LIMIT);

	logic [15:0] ptr_second;
	assign ptr_second = ptr[0] ? (ptr - 16'h0001) : (ptr + 16'h0001);

	// Execute datapath
	logic        is_byte;
	logic        is_ta;
	logic        uns_eff;
	logic [7:0]  byte_sel;
	logic [15:0] mem16_sign;
	logic [15:0] mem16_zero;
	logic [39:0] acc_mem;
	logic [15:0] ta_mem;
	logic        imm_det;
	logic        imm_sat;
	logic [4:0]  imm_shamt;
	logic [39:0] imm_result;
	logic        imm_ovf;
	logic [1:0]  acc_idx;
	logic [2:0]  ta_idx;
	logic        exec;
	logic        exec_imm;
	logic        exec_pair;

	assign exec      = (state == ST_EXEC);
	assign exec_imm  = exec & ((cmd.op == OP_IMM_S16) | (cmd.op == OP_IMM_SHV));
	assign exec_pair = exec & (cmd.op == OP_PAIR_LO);
	assign is_byte   = (cmd.op == OP_BYTE_HI) | (cmd.op == OP_BYTE_LO);
	assign is_ta     = cmd.dst[3];
	assign acc_idx   = cmd.dst[1:0];
	assign ta_idx    = cmd.dst[2:0];
	assign uns_eff   = cmd.uns & is_byte;
	assign byte_sel  = (cmd.op == OP_BYTE_HI) ? word_hi[15:8] : word_hi[7:0];
	assign mem16_sign = is_byte ? {{8{byte_sel[7]}}, byte_sel} : word_hi;
	assign mem16_zero = is_byte ? {8'h00, byte_sel} : word_hi;
	assign acc_mem = (mode.sign_ext_mode & ~uns_eff) ? {{24{mem16_sign[15]}}, mem16_sign}
	                                                 : {24'h00_0000, mem16_zero};
	assign ta_mem  = uns_eff ? mem16_zero : mem16_sign;

	assign imm_det   = (cmd.op == OP_IMM_S16) | ~mode.legacy_compat_mode;
	assign imm_sat   = mode.data_saturate_mode & ~mode.legacy_compat_mode;
	assign imm_shamt = (cmd.op == OP_IMM_S16) ? SHIFT_16 : {1'b0, cmd.shift_amount_field};

	imm_shifter u_shifter (
		.operand (imm16_const),
		.sign_en (mode.sign_ext_mode),
		.shamt   (imm_shamt),
		.wide    (mode.wide_acc_mode),
		.det_en  (imm_det),
		.sat_en  (imm_sat),
		.result  (imm_result),
		.ovf     (imm_ovf)
	);

	// Events
	logic [N_EV-1:0] ev_set;
	logic [N_EV-1:0] ev_status;
	logic [N_EV-1:0] ev_mask;
	logic            cmd_reject;

	assign cmd_reject            = wr_cmd & (~new_legal | new_fault);
	assign ev_set[EV_DONE]       = exec;
	assign ev_set[EV_OVF]        = exec_imm & imm_ovf;
	assign ev_set[EV_FAULT]      = wr_cmd & new_fault;
	assign ev_set[EV_ILLEGAL]    = wr_cmd & ~new_legal;

	event_status #(
		.N (N_EV)
	) u_events (
		.core_clk (core_clk),
		.reset    (reset),
		.ev_set   (ev_set),
		.ev_clr   (rd_event),
		.mask_we  (wr_mask),
		.mask_wd  (avs_writedata[N_EV-1:0]),
		.status   (ev_status),
		.mask     (ev_mask),
		.irq      (irq)
	);

	// Read mux
	assign rd_acc_idx = avs_address[4:3];
	assign rd_ta_idx  = avs_address[4:2];
	assign rd_acc     = acc_reg[rd_acc_idx];
	assign rd_value =
		(avs_address == OFS_MODE)  ? {28'h000_0000, mode} :
		(avs_address == OFS_CMD)   ? {20'h0_0000, cmd} :
		(avs_address == OFS_IMM)   ? {16'h0000, imm16_const} :
		(avs_address == OFS_PTR)   ? {16'h0000, ptr} :
		(avs_address == OFS_STATE) ? {27'h000_0000, acc_overflow_flag, busy} :
		(avs_address == OFS_EVENT) ? {28'h000_0000, ev_status} :
		(avs_address == OFS_MASK)  ? {28'h000_0000, ev_mask} :
		(avs_address[6:5] == OFS_ACC[6:5]) ?
			(avs_address[2] ? {24'h00_0000, rd_acc[39:32]} : rd_acc[31:0]) :
		(avs_address[6:5] == OFS_TA[6:5])  ? {16'h0000, ta_reg[rd_ta_idx]} :
		32'h0000_0000;

	// Bus handshake: one wait cycle, all accesses stall while a load runs
	always_ff @(posedge core_clk) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= ~(req & avs_waitrequest & ~busy);
			if (req & avs_waitrequest)
				avs_readdata <= rd_value;
		end
	end

	// Software-written controls
	always_ff @(posedge core_clk) begin
		if (reset) begin
			mode        <= mode_s'(MODE_RST);
			imm16_const <= 16'h0000;
			ptr         <= 16'h0000;
		end else begin
			if (wr_mode)
				mode <= mode_s'(avs_writedata[3:0]);
			if (wr_imm)
				imm16_const <= avs_writedata[15:0];
			if (wr_ptr)
				ptr <= avs_writedata[15:0];
		end
	end

	// Sequencer and memory fetch
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state         <= ST_IDLE;
			cmd           <= cmd_s'(12'h000);
			mem_rd        <= 1'b0;
			mem_addr      <= 16'h0000;
			word_hi       <= 16'h0000;
			word_lo       <= 16'h0000;
			bus_fault_irq <= 1'b0;
		end else begin
			bus_fault_irq <= wr_cmd & new_fault;
			unique case (state)
				ST_IDLE: begin
					if (wr_cmd & ~cmd_reject) begin
						cmd <= new_cmd;
						if (new_needs_mem) begin
							mem_rd   <= 1'b1;
							mem_addr <= ptr;
							state    <= ST_LAT;
						end else begin
							state <= ST_EXEC;
						end
					end
				end
				ST_LAT: begin
					mem_rd   <= (cmd.op == OP_PAIR_LO);
					mem_addr <= ptr_second;
					state    <= ST_DATA1;
				end
				ST_DATA1: begin
					mem_rd  <= 1'b0;
					word_hi <= mem_rdata;
					state   <= (cmd.op == OP_PAIR_LO) ? ST_DATA2 : ST_EXEC;
				end
				ST_DATA2: begin
					word_lo <= mem_rdata;
					state   <= ST_EXEC;
				end
				ST_EXEC: begin
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < N_ACC; i++)
				acc_reg[i] <= 40'h00_0000_0000;
			for (int i = 0; i < N_TA; i++)
				ta_reg[i] <= 16'h0000;
			acc_overflow_flag <= '0;
		end else if (exec) begin
			if (exec_pair) begin
				acc_reg[acc_idx][15:0]                  <= word_hi;
				acc_reg[acc_idx | 2'b01][15:0]          <= word_lo;
			end else if (exec_imm) begin
				acc_reg[acc_idx] <= imm_result;
				if (imm_ovf)
					acc_overflow_flag[acc_idx] <= 1'b1;
			end else if (is_ta) begin
				ta_reg[ta_idx] <= ta_mem;
			end else begin
				acc_reg[acc_idx] <= acc_mem;
			end
		end
	end
endmodule : dsp_load_unit

//--- verif/data_mem_model.sv
// Purpose: Data memory on the far side of the load unit
// Assumes: Synchronous read, one cycle latency, word derived from address
// Notes:   Outside a read the data line toggles so stale words never match
`timescale 1ns/10ps
module data_mem_model (
	input  wire logic        core_clk,  // Core clock
	input  wire logic [15:0] mem_addr,  // Word address
	input  wire logic        mem_rd,    // Read strobe
	output logic      [15:0] mem_rdata  // Read word
);
	initial mem_rdata = 16'h0000;
	always @(posedge core_clk) begin
		if (mem_rd)
			mem_rdata <= {~mem_addr[7:0], mem_addr[7:0]};
		else
			mem_rdata <= ~mem_rdata;
	end
endmodule : data_mem_model

//--- verif/dsp_load_unit_assertions.sv
// Purpose: Port-level checks of the load datapath
// Assumes: Bound to every load unit instance
// Notes:   Sees only the top ports
`timescale 1ns/10ps
module dsp_load_unit_assertions
	import dsp_load_pkg::*;
(
	input wire logic              core_clk,          // Core clock
	input wire logic              reset,             // Sync reset
	input wire logic [ADDR_W-1:0] avs_address,       // Register address
	input wire logic              avs_read,          // Read request
	input wire logic              avs_write,         // Write request
	input wire logic              avs_waitrequest,   // Stall
	input wire logic [MEM_AW-1:0] mem_addr,          // Memory address
	input wire logic              mem_rd,            // Memory strobe
	input wire logic              bus_fault_irq,     // Fault pulse
	input wire logic [N_ACC-1:0]  acc_overflow_flag, // Overflow flags
	input wire logic              irq                // Interrupt
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	wait_one_cycle_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	wait_needs_req_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
		else $error("waitrequest fell without a request");
	reset_values_a: assert property ($fell(reset) |-> avs_waitrequest && !mem_rd && !irq && acc_overflow_flag == 4'h0)
		else $error("outputs not at reset values");
	fetch_start_a: assert property ($rose(mem_rd) |-> $past(avs_write && !avs_waitrequest && avs_address == OFS_CMD))
		else $error("memory fetch without accepted command");
	fetch_len_a: assert property (mem_rd ##1 mem_rd |=> !mem_rd)
		else $error("memory strobe longer than two cycles");
	pair_addr_a: assert property ($rose(mem_rd) ##1 mem_rd |-> mem_addr == $past(mem_addr) + ($past(mem_addr[0]) ? 16'hFFFF : 16'h0001))
		else $error("second word address wrong");
	fault_pulse_a: assert property (bus_fault_irq |=> !bus_fault_irq)
		else $error("bus fault pulse longer than one cycle");
	flag_sticky_a: assert property ((acc_overflow_flag & $past(acc_overflow_flag)) == $past(acc_overflow_flag))
		else $error("overflow flag cleared without reset");
endmodule : dsp_load_unit_assertions
bind dsp_load_unit dsp_load_unit_assertions i_chk (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .mem_addr(mem_addr),
	.mem_rd(mem_rd), .bus_fault_irq(bus_fault_irq), .acc_overflow_flag(acc_overflow_flag), .irq(irq));

//--- verif/dsp_load_unit_bench.sv
// Purpose: Self-checking bench of the load datapath
// Assumes: Memory word at address a is {~a[7:0], a[7:0]}
// Notes:   Reset check, table rows, then overflow, illegal pair, faults and reset by hand
`timescale 1ns/10ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin bad_count++; \
	$display("FAIL %0t: got %h expected %h", $time, got, exp); end end
module dsp_load_unit_bench
	import dsp_load_pkg::*;
;
	typedef struct packed {
		logic [3:0]  mode;
		logic [15:0] imm;
		logic [15:0] ptr;
		logic [11:0] cmd;
		logic [6:0]  ra;
		logic [31:0] exp;
	} row_s;
	logic              core_clk, reset, avs_read, avs_write, avs_waitrequest, mem_rd, bus_fault_irq, irq;
	logic [ADDR_W-1:0] avs_address;
	logic [31:0]       avs_writedata, avs_readdata;
	logic [15:0]       mem_addr, mem_rdata;
	logic [N_ACC-1:0]  acc_overflow_flag;
	int                bad_count = 0, checked = 0, faults = 0;
	row_s              rows [18] = '{
		'{4'h0, 16'h0000, 16'h0100, 12'h000, 7'h20, 32'h0000_FF00}, '{4'h0, 16'h0000, 16'h0000, 12'hFFF, 7'h28, 32'h0000_FE01},
		'{4'h0, 16'h0000, 16'h0103, 12'h010, 7'h30, 32'h0000_FC03}, '{4'h0, 16'h0000, 16'h0000, 12'hFFF, 7'h38, 32'h0000_FD02},
		'{4'h0, 16'h0001, 16'h0000, 12'h001, 7'h20, 32'h0001_0000}, '{4'h3, 16'hFFFE, 16'h0000, 12'h001, 7'h24, 32'h0000_00FF},
		'{4'h0, 16'h0000, 16'h0000, 12'hFFF, 7'h20, 32'hFFFE_0000}, '{4'h1, 16'hFFFE, 16'h0000, 12'h78A, 7'h28, 32'hFFFF_0000},
		'{4'h0, 16'h0000, 16'h0000, 12'hFFF, 7'h2C, 32'h0000_00FF}, '{4'h1, 16'h0000, 16'h0100, 12'h01B, 7'h38, 32'hFFFF_FF00},
		'{4'h0, 16'h0000, 16'h0100, 12'h01B, 7'h3C, 32'h0000_0000}, '{4'h1, 16'h0000, 16'h0100, 12'h053, 7'h48, 32'h0000_FF00},
		'{4'h0, 16'h0000, 16'h0100, 12'h804, 7'h20, 32'h0000_00FF}, '{4'h0, 16'h0000, 16'h0181, 12'h04D, 7'h44, 32'h0000_FF81},
		'{4'h1, 16'h0000, 16'h0100, 12'h014, 7'h30, 32'hFFFF_FFFF}, '{4'h0, 16'h0000, 16'h0000, 12'hFFF, 7'h34, 32'h0000_00FF},
		'{4'h1, 16'h0000, 16'h0181, 12'h80D, 7'h28, 32'h0000_0081}, '{4'h0, 16'h0000, 16'h0000, 12'hFFF, 7'h2C, 32'h0000_0000}};
	dsp_load_unit #(.MAP_LIMIT(16'h0060)) i_dut (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
		.bus_fault_irq(bus_fault_irq), .acc_overflow_flag(acc_overflow_flag), .irq(irq));
	data_mem_model i_mem (.core_clk(core_clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (bus_fault_irq === 1'b1)
			faults <= faults + 1;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		`CHK(n <= 7, 1'b1)
	endtask : bus
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic chk_rd(input logic [6:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		`CHK(q & m, e)
	endtask : chk_rd
	task automatic load(input logic [3:0] md, input logic [15:0] im, input logic [15:0] p, input logic [11:0] c);
		wr(OFS_MODE, 32'(md));
		wr(OFS_IMM, 32'(im));
		wr(OFS_PTR, 32'(p));
		wr(OFS_CMD, 32'(c));
	endtask : load
	initial begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		report_and_stop();
	end
	initial begin
		reset = 1'b1;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		repeat (16) @(posedge core_clk);
		`CHK(avs_waitrequest, 1'b1)
		reset <= 1'b0;
		chk_rd(OFS_MODE, 32'h0000_0000);
		$display("reset test done");
		for (int i = 0; i < 18; i++) begin
			if (rows[i].cmd != 12'hFFF)
				load(rows[i].mode, rows[i].imm, rows[i].ptr, rows[i].cmd);
			chk_rd(rows[i].ra, rows[i].exp);
		end
		$display("table test done");
		load(4'h4, 16'h8000, 16'h0000, 12'h001);
		chk_rd(7'h20, 32'h7FFF_FFFF);
		`CHK(acc_overflow_flag, 4'h1)
		load(4'hC, 16'h8000, 16'h0000, 12'h009);
		chk_rd(7'h28, 32'h8000_0000);
		load(4'hD, 16'h8000, 16'h0000, 12'h792);
		chk_rd(7'h30, 32'hC000_0000);
		`CHK(acc_overflow_flag, 4'h3)
		chk_rd(OFS_STATE, 32'h0000_0006);
		$display("overflow test done");
		chk_rd(OFS_EVENT, 32'h0000_0003);
		load(4'h0, 16'h0000, 16'h0100, 12'h008);
		chk_rd(OFS_EVENT, 32'h0000_0008, 32'h0000_0008);
		chk_rd(OFS_EVENT, 32'h0000_0000, 32'h0000_0008);
		chk_rd(7'h28, 32'h8000_0000);
		$display("illegal pair test done");
		wr(OFS_MASK, 32'h0000_0004);
		load(4'h0, 16'h0000, 16'h005F, 12'h004);
		chk_rd(7'h20, 32'h7FFF_FFFF);
		`CHK(faults, 1)
		`CHK(irq, 1'b1)
		chk_rd(OFS_EVENT, 32'h0000_0004, 32'h0000_0004);
		repeat (3) @(posedge core_clk);
		`CHK(irq, 1'b0)
		load(4'h0, 16'h0000, 16'h0060, 12'h004);
		chk_rd(7'h20, 32'h0000_009F);
		`CHK(faults, 1)
		wr(OFS_MASK, 32'h0000_0000);
		load(4'h0, 16'h0000, 16'h0000, 12'h00D);
		chk_rd(OFS_STATE, 32'h0000_0000, 32'h0000_0001);
		`CHK(irq, 1'b0)
		chk_rd(OFS_EVENT, 32'h0000_0004, 32'h0000_0004);
		`CHK(faults, 2)
		$display("fault test done");
		wr(7'h1C, 32'hFFFF_FFFF);
		chk_rd(7'h1C, 32'h0000_0000);
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		chk_rd(7'h20, 32'h0000_0000);
		`CHK(acc_overflow_flag, 4'h0)
		$display("second reset test done");
		report_and_stop();
	end
endmodule : dsp_load_unit_bench
